// ===== src/uic_core.sv
// Interrupt status, enable, class and polarity logic with register port
`timescale 1ns/10ps
module uic_core
  import uic_pkg::*;
#(
  parameter int NEXT = 7
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [9:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  output logic                   reg_ack,
  // On-chip sources, same clock
  input  wire logic              serial0_irq,
  input  wire logic              serial1_irq,
  input  wire logic              twi_irq,
  input  wire logic              ext_master_irq,
  input  wire logic [3:0]        dma_irq,
  input  wire logic              mem_correctable_err_irq,
  // External request pins
  input  wire logic [NEXT-1:0]   ext_request,
  // Toward the core
  output logic                   core_crit_irq,
  output logic                   core_noncrit_irq
);
  logic [31:0]     status_r, enable_r, class_r, polarity_r, trigger_r;
  logic [31:0]     status_nxt, enable_nxt, class_nxt, polarity_nxt, trigger_nxt;
  logic [31:0]     raw_prev_r, raw_prev_nxt;
  logic [31:0]     rdata_r, rdata_nxt;
  logic            ack_r, ack_nxt, crit_r, crit_nxt, ncrit_r, ncrit_nxt;
  logic [NEXT-1:0] ext_sync;
  logic [31:0]     raw, active, edge_hit, request, clr, wmask, pend;
  logic            hit_status, hit_enable, hit_class, hit_polarity, hit_trigger;

  // ==========================================
  // Pin synchroniser
  uic_pin_sync #(.WIDTH(NEXT)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   (ext_request),
    .pin_sync (ext_sync)
  );

  // ==========================================
  // Source vector: reserved positions tied low
  always_comb begin
    raw = '0;
    raw[UIC_BIT_SER0]   = serial0_irq;
    raw[UIC_BIT_SER1]   = serial1_irq;
    raw[UIC_BIT_TWI]    = twi_irq;
    raw[UIC_BIT_EXTMST] = ext_master_irq;
    raw[UIC_BIT_DMA0 +: 4] = dma_irq;
    raw[UIC_BIT_MEMERR] = mem_correctable_err_irq;
    raw[UIC_BIT_EXTREQ0 +: NEXT] = ext_sync;
  end

  // ==========================================
  // Detection per source, one slice per bit position
  for (genvar i = 0; i < UIC_NSRC; i++) begin : g_src
    if (UIC_IMPL_MASK[i]) begin : g_live
      // Polarity 1 means high or rising; on-chip sources rely on software setting it
      assign active[i]   = polarity_r[i] ? raw[i] : ~raw[i];
      // Edge taken against the level sampled one clock earlier
      assign edge_hit[i] = polarity_r[i] ? (raw[i] & ~raw_prev_r[i])
                                         : (~raw[i] & raw_prev_r[i]);
      // Trigger bit picks which detector feeds the capture
      assign request[i]  = trigger_r[i] ? edge_hit[i] : active[i];
    end else begin : g_rsvd
      // No source behind this position, so nothing is ever captured
      assign active[i]   = 1'b0;
      assign edge_hit[i] = 1'b0;
      assign request[i]  = 1'b0;
    end
  end

  // ==========================================
  // Register number decode for writes and status clear; reads decode reg_addr in their own case
  always_comb begin
    hit_status   = (reg_addr == UIC_ADDR_STATUS);
    hit_enable   = (reg_addr == UIC_ADDR_ENABLE);
    hit_class    = (reg_addr == UIC_ADDR_CLASS);
    hit_polarity = (reg_addr == UIC_ADDR_POLARITY);
    hit_trigger  = (reg_addr == UIC_ADDR_TRIGGER);
    // Reserved positions dropped on the way in, so no register can ever hold one
    wmask        = reg_wdata & UIC_IMPL_MASK;
  end

  // ==========================================
  // Configuration: enable, class, polarity and trigger
  always_comb begin
    enable_nxt   = enable_r;
    class_nxt    = class_r;
    polarity_nxt = polarity_r;
    trigger_nxt  = trigger_r;
    // Unmapped numbers match no hit and are ignored
    if (reg_wr) begin
      if (hit_enable) begin
        enable_nxt = wmask;
      end
      if (hit_class) begin
        class_nxt = wmask;
      end
      if (hit_polarity) begin
        polarity_nxt = wmask;
      end
      if (hit_trigger) begin
        trigger_nxt = wmask;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_r   <= UIC_RST_ENABLE;
      class_r    <= UIC_RST_CLASS;
      polarity_r <= UIC_RST_POLARITY;
      trigger_r  <= UIC_RST_TRIGGER;
    end else begin
      enable_r   <= enable_nxt;
      class_r    <= class_nxt;
      polarity_r <= polarity_nxt;
      trigger_r  <= trigger_nxt;
    end
  end

  // ==========================================
  // Status capture
  always_comb begin
    // Write one clears, write zero leaves the flag alone
    clr        = (reg_wr && hit_status) ? wmask : '0;
    // Set beats clear; with trigger 0 an active level re-sets the flag so its clear has no effect
    status_nxt = ((status_r & ~clr) | request) & UIC_IMPL_MASK;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_r <= UIC_RST_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ==========================================
  // Edge history: level of every source one clock back
  always_comb begin
    raw_prev_nxt = raw;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      raw_prev_r <= '0;
    end else begin
      raw_prev_r <= raw_prev_nxt;
    end
  end

  // ==========================================
  // Register reads, one cycle after the strobe
  always_comb begin
    rdata_nxt = rdata_r;
    // Every strobe is answered, mapped or not, so software never stalls
    ack_nxt   = reg_rd | reg_wr;
    if (reg_rd) begin
      unique case (reg_addr)
        UIC_ADDR_STATUS:   rdata_nxt = status_r;
        UIC_ADDR_ENABLE:   rdata_nxt = enable_r;
        UIC_ADDR_CLASS:    rdata_nxt = class_r;
        UIC_ADDR_POLARITY: rdata_nxt = polarity_r;
        UIC_ADDR_TRIGGER:  rdata_nxt = trigger_r;
        default:           rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= '0;
      ack_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ack_r   <= ack_nxt;
    end
  end

  // ==========================================
  // Routing to the core
  always_comb begin
    pend      = status_r & enable_r;
    // Both outputs may stand at once when enabled flags differ in class
    crit_nxt  = |(pend & class_r);
    ncrit_nxt = |(pend & ~class_r);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crit_r  <= 1'b0;
      ncrit_r <= 1'b0;
    end else begin
      crit_r  <= crit_nxt;
      ncrit_r <= ncrit_nxt;
    end
  end

  // ==========================================
  // Outputs straight from their flip-flops
  assign reg_rdata        = rdata_r;
  assign reg_ack          = ack_r;
  assign core_crit_irq    = crit_r;
  assign core_noncrit_irq = ncrit_r;
endmodule // uic_core

// ===== src/uic_pkg.sv
// Package: register map, source bit layout and reset values of the interrupt block
package uic_pkg;
  // ==========================================
  // Register map (device control register numbers)
  localparam logic [9:0] UIC_ADDR_STATUS   = 10'h0C0;
  localparam logic [9:0] UIC_ADDR_ENABLE   = 10'h0C2;
  localparam logic [9:0] UIC_ADDR_CLASS    = 10'h0C3;
  localparam logic [9:0] UIC_ADDR_POLARITY = 10'h0C4;
  localparam logic [9:0] UIC_ADDR_TRIGGER  = 10'h0C5;

  // ==========================================
  // Source layout
  localparam int          UIC_NSRC        = 32;
  localparam int          UIC_BIT_SER0    = 0;
  localparam int          UIC_BIT_SER1    = 1;
  localparam int          UIC_BIT_TWI     = 2;
  localparam int          UIC_BIT_EXTMST  = 3;
  localparam int          UIC_BIT_DMA0    = 5;
  localparam int          UIC_BIT_MEMERR  = 17;
  localparam int          UIC_BIT_EXTREQ0 = 25;
  localparam logic [31:0] UIC_IMPL_MASK   = 32'hFE0201EF;
  localparam logic [31:0] UIC_ONCHIP_MASK = 32'h000201EF;

  // ==========================================
  // Reset values
  localparam logic [31:0] UIC_RST_STATUS   = 32'h00000000;
  localparam logic [31:0] UIC_RST_ENABLE   = 32'h00000000;
  localparam logic [31:0] UIC_RST_CLASS    = 32'h00000000;
  localparam logic [31:0] UIC_RST_POLARITY = 32'h00000000;
  localparam logic [31:0] UIC_RST_TRIGGER  = 32'h00000000;

  // ==========================================
  // Input synchroniser depth for pins
  localparam int          UIC_SYNC_STAGES  = 3;
endpackage

// ===== src/uic_pin_sync.sv
// Three-stage synchroniser for the external request pins
`timescale 1ns/10ps
module uic_pin_sync
  import uic_pkg::*;
#(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Pins in, settled level out
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, q_r;
  logic [WIDTH-1:0] s1_nxt, s2_nxt, s3_nxt, q_nxt;

  // ==========================================
  // Next values: a change counts once stages two and three agree
  always_comb begin
    s1_nxt = pin_in;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    q_nxt  = q_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        q_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      q_r  <= q_nxt;
    end
  end

  assign pin_sync = q_r;
endmodule // uic_pin_sync

// ===== bench/uic_core_sva.sv
// Port checker for the interrupt core
`timescale 1ns/10ps
module uic_core_sva
  import uic_pkg::*;
(
  // Clock, reset, register port
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  // Core outputs
  input wire logic core_crit_irq,
  input wire logic core_noncrit_irq
);
  logic [31:0] en_r;
  // Enable shadow, lags the design by nothing
  always_ff @(posedge clk)
    if (!rst_n) en_r <= 32'h0;
    else if (reg_wr && reg_addr == UIC_ADDR_ENABLE) en_r <= reg_wdata & UIC_IMPL_MASK;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_next: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("no ack");
  a_ack_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd)) else $error("stray ack");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("rdata moved");
  a_rsvd_zero: assert property (reg_ack |-> !(reg_rdata & ~UIC_IMPL_MASK)) else $error("reserved bit");
  a_unmapped_zero: assert property (reg_ack && $past(reg_rd && reg_addr == 10'h0C1) |-> !reg_rdata)
    else $error("unmapped read");
  a_enable_read: assert property (reg_ack && $past(reg_rd && reg_addr == UIC_ADDR_ENABLE)
    |-> reg_rdata == $past(en_r)) else $error("enable read");
  a_crit_gate: assert property (core_crit_irq |-> $past(en_r) != 32'h0) else $error("crit gate");
  a_nc_gate: assert property (core_noncrit_irq |-> $past(en_r) != 32'h0) else $error("nc gate");
  c_crit: cover property (core_crit_irq);
  c_noncrit: cover property (core_noncrit_irq);
  c_wr_rd: cover property (reg_wr ##2 reg_rd);
endmodule // uic_core_sva
bind uic_core uic_core_sva uic_core_sva_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .core_crit_irq(core_crit_irq), .core_noncrit_irq(core_noncrit_irq));

// ===== bench/uic_cpu.sv
// Core side model: counts new interrupt requests
`timescale 1ns/10ps
module uic_cpu (
  // Core inputs
  input wire logic clk,
  input wire logic rst_n,
  input wire logic crit,
  input wire logic nc,
  // Request counts
  output logic [7:0] n_crit,
  output logic [7:0] n_nc
);
  logic c_q, n_q;
  // A held level counts once, as the core sees one request
  always_ff @(posedge clk) begin
    c_q <= crit;
    n_q <= nc;
    n_crit <= rst_n ? n_crit + 8'(crit & ~c_q) : 8'h0;
    n_nc <= rst_n ? n_nc + 8'(nc & ~n_q) : 8'h0;
  end
endmodule // uic_cpu

// ===== bench/tb_interrupt_status_enable_class.sv
// Self-checking bench for the interrupt status block
`timescale 1ns/10ps
module tb_interrupt_status_enable_class
  import uic_pkg::*;
;
  typedef struct packed {logic [31:0] s, e, c; logic [1:0] o;} uic_row_s;
  // Sources, enable, class, expected {crit, noncrit}
  uic_row_s rows [5] = '{'{32'h1, 32'h1, 32'h1, 2'h2}, '{32'h2, 32'h2, 32'h0, 2'h1},
    '{32'h20104, 32'h0, 32'h0, 2'h0}, '{32'h80000000, 32'hFFFFFFFF, 32'h0, 2'h1},
    '{32'h2000008, 32'h2000008, 32'hFFFFFFFF, 2'h2}};
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_ack, crit, nc;
  logic [9:0] reg_addr = 10'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, src = 32'h0;
  logic [7:0] n_crit, n_nc;
  int fail_count = 0, checks = 0;
  always #5 clk = ~clk;
  uic_core uic_core_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .serial0_irq(src[0]), .serial1_irq(src[1]),
    .twi_irq(src[2]), .ext_master_irq(src[3]), .dma_irq(src[8:5]), .mem_correctable_err_irq(src[17]),
    .ext_request(src[31:25]), .core_crit_irq(crit), .core_noncrit_irq(nc));
  uic_cpu uic_cpu_i (.clk(clk), .rst_n(rst_n), .crit(crit), .nc(nc), .n_crit(n_crit), .n_nc(n_nc));
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Run needs about 230 cycles
  initial begin
    #20000;
    fail_count++;
    conclude;
  end
  // ==========
  // Tests
  initial begin
    idle(5);
    rst_n = 1'b1;
    wr(UIC_ADDR_POLARITY, 32'hFFFFFFFF);
    wr(UIC_ADDR_STATUS, 32'hFFFFFFFF);
    foreach (rows[i]) begin
      wr(UIC_ADDR_ENABLE, rows[i].e);
      wr(UIC_ADDR_CLASS, rows[i].c);
      src = rows[i].s;
      idle(8);
      rd(UIC_ADDR_STATUS, rows[i].s);
      chk({30'h0, crit, nc}, {30'h0, rows[i].o});
      src = 32'h0;
      idle(8);
      wr(UIC_ADDR_STATUS, ~rows[i].s);
      rd(UIC_ADDR_STATUS, rows[i].s);
      wr(UIC_ADDR_STATUS, rows[i].s);
      rd(UIC_ADDR_STATUS, 32'h0);
      $display("row %0d done", i);
    end
    chk({16'h0, n_nc, n_crit}, 32'h0202);
    src = 32'h1;
    idle(2);
    wr(UIC_ADDR_STATUS, 32'h1);
    rd(UIC_ADDR_STATUS, 32'h1);
    src = 32'h0;
    idle(2);
    wr(UIC_ADDR_STATUS, 32'h1);
    rd(UIC_ADDR_STATUS, 32'h0);
    wr(UIC_ADDR_CLASS, 32'hFFFFFFFF);
    rd(UIC_ADDR_CLASS, UIC_IMPL_MASK);
    rd(10'h0C1, 32'h0);
    $display("level and map done");
    wr(UIC_ADDR_TRIGGER, 32'h2000000);
    src = 32'h2000000;
    idle(8);
    rd(UIC_ADDR_STATUS, 32'h2000000);
    wr(UIC_ADDR_STATUS, 32'h2000000);
    rd(UIC_ADDR_STATUS, 32'h0);
    wr(UIC_ADDR_POLARITY, ~32'h2000000);
    src = 32'h0;
    idle(8);
    rd(UIC_ADDR_STATUS, 32'h2000000);
    wr(UIC_ADDR_STATUS, 32'h2000000);
    rd(UIC_ADDR_STATUS, 32'h0);
    $display("edge done");
    src = 32'h0;
    rst_n = 1'b0;
    idle(4);
    rst_n = 1'b1;
    for (int a = 2; a < 6; a++) rd(10'h0C0 + 10'(a), 32'h0);
    idle(8);
    rd(UIC_ADDR_STATUS, UIC_IMPL_MASK);
    $display("reset done");
    conclude;
  end
endmodule // tb_interrupt_status_enable_class
